// File: verilog/tsu_params.svh
// Constants for the transfer and skip timing unit.
// Assumes inclusion by bare name from the package, the core, the checker and the bench.
`ifndef TSU_PARAMS_SVH
`define TSU_PARAMS_SVH

// APB register byte offsets
`define TSU_OFS_INSTR 12'h000
`define TSU_OFS_CFG 12'h004
`define TSU_OFS_REGS 12'h008
`define TSU_OFS_STAT 12'h00C

// Config field positions
`define TSU_CFG_MBE_BIT 0
`define TSU_CFG_MBS_LO 4
`define TSU_CFG_PCC_LO 8

// Reset values
`define TSU_CFG_RST 32'h0000_0000
`define TSU_REGS_RST 24'h00_0000

// Machine cycle lengths in pclk cycles, one per clock select setting
`define TSU_DIV0 8'h04
`define TSU_DIV1 8'h08
`define TSU_DIV2 8'h10
`define TSU_DIV3 8'h40

// Bank select values that exist
`define TSU_BANK_LO 4'h0
`define TSU_BANK_ONE 4'h1
`define TSU_BANK_HI 4'hF

// Skip costs in machine cycles
`define TSU_S_NONE 2'h0
`define TSU_S_SHORT 2'h1
`define TSU_S_LONG 2'h2

// Base machine cycles of the table-indirect call
`define TSU_TABLE_INDIRECT_CALL_INSTR_CYC 4'h3

`endif

// File: verilog/tsu_pkg.sv
// Types for the transfer and skip timing unit.
// Assumes tsu_params.svh is on the include path.
`include "tsu_params.svh"

package tsu_pkg;

	typedef enum logic [3:0] {
		TSU_OP_OTHER = 4'h0,
		TSU_OP_MOV_A_IMM = 4'h1,
		TSU_OP_MOV_XA_IMM = 4'h2,
		TSU_OP_MOV_PTR_IMM = 4'h3,
		TSU_OP_MOV_A_PTR = 4'h4,
		TSU_OP_MOV_A_PTR_INC = 4'h5,
		TSU_OP_MOV_A_PTR_DEC = 4'h6,
		TSU_OP_XCH_A_PTR = 4'h7,
		TSU_OP_XCH_A_PTR_INC = 4'h8,
		TSU_OP_XCH_A_PTR_DEC = 4'h9,
		TSU_OP_MOV_A_DE = 4'hA,
		TSU_OP_MOV_A_MEM = 4'hB,
		TSU_OP_MOV_MEM_A = 4'hC,
		TSU_OP_XCH_A_MEM = 4'hD,
		TSU_OP_TABLE_CALL = 4'hE,
		TSU_OP_ABS_BRANCH = 4'hF
	} tsu_op_t;

	typedef enum logic [1:0] {
		TSU_ST_IDLE = 2'b01,
		TSU_ST_RUN = 2'b10
	} tsu_state_t;

	typedef enum logic [1:0] {
		TSU_STR_NONE = 2'h0,
		TSU_STR_A = 2'h1,
		TSU_STR_B = 2'h2
	} tsu_str_t;

	// Instruction word written by software
	typedef struct packed {
		logic [3:0] rsv_hi;
		logic [11:0] addr;
		logic [7:0] imm;
		logic [1:0] rsv_lo;
		logic [1:0] bytes;
		tsu_op_t op;
	} tsu_instr_t;

	// Working registers
	typedef struct packed {
		logic [3:0] e;
		logic [3:0] d;
		logic [3:0] l;
		logic [3:0] h;
		logic [3:0] x;
		logic [3:0] a;
	} tsu_regs_t;

endpackage

// File: verilog/tsu_mem.sv
// Data memory for the transfer unit: one write port, registered read.
// Assumes a single clock; array contents are not reset.
`timescale 1ns/1ps
`default_nettype none

module tsu_mem #(
	parameter int AW = 10,
	parameter int DW = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [AW-1:0] addr,
	input wire logic we,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem_ff [0:(1<<AW)-1];
	logic [DW-1:0] rdata_ff;

	always_ff @(posedge clk) begin
		if (we) begin
			mem_ff[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem_ff[addr];
		end
	end

	assign rdata = rdata_ff;

endmodule // tsu_mem

`default_nettype wire

// File: verilog/tsu_core.sv
// Transfer instruction executor with skip timing, APB register slave.
// Assumes a 250 MHz pclk and an APB master on the same clock.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tsu_params.svh"

module tsu_core #(
	parameter int AW = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic exec_busy
);

	tsu_pkg::tsu_state_t state_ff;
	tsu_pkg::tsu_instr_t instr_ff;
	tsu_pkg::tsu_regs_t regs_ff;
	tsu_pkg::tsu_str_t str_ff;
	tsu_pkg::tsu_instr_t nxt_instr;
	logic [31:0] cfg_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic skip_pend_ff;
	logic discard_ff;
	logic [7:0] div_cnt_ff;
	logic mc_en_ff;
	logic [3:0] cyc_ff;
	logic [3:0] target_ff;
	logic [3:0] last_cyc_ff;
	logic last_disc_ff;
	logic [AW-1:0] maddr_ff;
	logic [3:0] mem_rdata;
	logic mem_we;
	logic wr_acc;
	logic issue;
	logic commit;
	logic mapped;
	logic do_discard;
	logic [3:0] nxt_base;
	logic [3:0] nxt_ptr_l;
	logic [31:0] rd_val;

	// Bank number to memory block index
	function automatic logic [1:0] bank_idx(input logic [3:0] bank);
		case (bank)
			`TSU_BANK_ONE: bank_idx = 2'h1;
			`TSU_BANK_HI: bank_idx = 2'h2;
			default: bank_idx = 2'h0;
		endcase
	endfunction

	// Enable AND select gives the active memory bank
	function automatic logic [3:0] active_memory_bank(input logic [31:0] cfg);
		active_memory_bank = cfg[`TSU_CFG_MBE_BIT] ? cfg[`TSU_CFG_MBS_LO +: 4] : 4'h0;
	endfunction

	// Machine cycle length for a clock select value
	function automatic logic [7:0] div_of(input logic [1:0] sel);
		case (sel)
			2'h0: div_of = `TSU_DIV0;
			2'h1: div_of = `TSU_DIV1;
			2'h2: div_of = `TSU_DIV2;
			default: div_of = `TSU_DIV3;
		endcase
	endfunction

	// String-effect group of an immediate load
	function automatic tsu_pkg::tsu_str_t str_of(input tsu_pkg::tsu_op_t op);
		case (op)
			tsu_pkg::TSU_OP_MOV_A_IMM: str_of = tsu_pkg::TSU_STR_A;
			tsu_pkg::TSU_OP_MOV_XA_IMM: str_of = tsu_pkg::TSU_STR_A;
			tsu_pkg::TSU_OP_MOV_PTR_IMM: str_of = tsu_pkg::TSU_STR_B;
			default: str_of = tsu_pkg::TSU_STR_NONE;
		endcase
	endfunction

	// Cost of discarding an instruction
	function automatic logic [3:0] skip_cost(input tsu_pkg::tsu_instr_t ins);
		if (ins.op == tsu_pkg::TSU_OP_TABLE_CALL) begin
			skip_cost = {2'h0, `TSU_S_SHORT};
		end else if (ins.op == tsu_pkg::TSU_OP_ABS_BRANCH || ins.bytes == 2'h3) begin
			skip_cost = {2'h0, `TSU_S_LONG};
		end else begin
			skip_cost = {2'h0, `TSU_S_SHORT};
		end
	endfunction

	assign nxt_instr = tsu_pkg::tsu_instr_t'(pwdata);
	assign wr_acc = psel && penable && pready_ff && pwrite;
	assign issue = wr_acc && paddr[11:0] == `TSU_OFS_INSTR && state_ff == tsu_pkg::TSU_ST_IDLE;
	assign commit = state_ff == tsu_pkg::TSU_ST_RUN && mc_en_ff && cyc_ff + 4'h1 == target_ff;
	assign do_discard = skip_pend_ff || (str_of(nxt_instr.op) != tsu_pkg::TSU_STR_NONE
		&& str_of(nxt_instr.op) == str_ff);
	assign mapped = paddr[11:0] == `TSU_OFS_INSTR || paddr[11:0] == `TSU_OFS_CFG
		|| paddr[11:0] == `TSU_OFS_REGS || paddr[11:0] == `TSU_OFS_STAT;

	// Base cycles of an executed instruction
	always_comb begin
		case (nxt_instr.op)
			tsu_pkg::TSU_OP_MOV_A_IMM: nxt_base = 4'h1;
			tsu_pkg::TSU_OP_MOV_A_PTR: nxt_base = 4'h1;
			tsu_pkg::TSU_OP_XCH_A_PTR: nxt_base = 4'h1;
			tsu_pkg::TSU_OP_MOV_A_DE: nxt_base = 4'h1;
			tsu_pkg::TSU_OP_TABLE_CALL: nxt_base = `TSU_TABLE_INDIRECT_CALL_INSTR_CYC;
			tsu_pkg::TSU_OP_OTHER: nxt_base = (nxt_instr.bytes == 2'h0) ? 4'h1 : {2'h0, nxt_instr.bytes};
			default: nxt_base = 4'h2;
		endcase
	end

	// Memory address of the issued operand
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			maddr_ff <= '0;
		end else if (issue) begin
			case (nxt_instr.op)
				tsu_pkg::TSU_OP_MOV_A_DE: maddr_ff <= {2'h0, regs_ff.d, regs_ff.e};
				tsu_pkg::TSU_OP_MOV_A_MEM, tsu_pkg::TSU_OP_MOV_MEM_A, tsu_pkg::TSU_OP_XCH_A_MEM: begin
					if (cfg_ff[`TSU_CFG_MBE_BIT]) begin
						maddr_ff <= {bank_idx(cfg_ff[`TSU_CFG_MBS_LO +: 4]), nxt_instr.addr[7:0]};
					end else begin
						maddr_ff <= {bank_idx(nxt_instr.addr[7] ? `TSU_BANK_HI : `TSU_BANK_LO),
							nxt_instr.addr[7:0]};
					end
				end
				default: maddr_ff <= {bank_idx(active_memory_bank(cfg_ff)), regs_ff.h, regs_ff.l};
			endcase
		end
	end

	// Machine cycle enable, restarted at issue so memory data is settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= 8'h00;
			mc_en_ff <= 1'b0;
		end else if (issue || div_cnt_ff + 8'h01 >= div_of(cfg_ff[`TSU_CFG_PCC_LO +: 2])) begin
			div_cnt_ff <= 8'h00;
			mc_en_ff <= !issue;
		end else begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
			mc_en_ff <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= tsu_pkg::TSU_ST_IDLE;
			instr_ff <= '0;
			discard_ff <= 1'b0;
			cyc_ff <= 4'h0;
			target_ff <= 4'h1;
			last_cyc_ff <= 4'h0;
			last_disc_ff <= 1'b0;
		end else begin
			case (state_ff)
				tsu_pkg::TSU_ST_IDLE: begin
					if (issue) begin
						state_ff <= tsu_pkg::TSU_ST_RUN;
						instr_ff <= nxt_instr;
						discard_ff <= do_discard;
						cyc_ff <= 4'h0;
						target_ff <= do_discard ? skip_cost(nxt_instr) : nxt_base;
					end
				end
				tsu_pkg::TSU_ST_RUN: begin
					if (commit) begin
						state_ff <= tsu_pkg::TSU_ST_IDLE;
						last_cyc_ff <= target_ff;
						last_disc_ff <= discard_ff;
					end else if (mc_en_ff) begin
						cyc_ff <= cyc_ff + 4'h1;
					end
				end
				default: state_ff <= tsu_pkg::TSU_ST_IDLE;
			endcase
		end
	end

	// Skip pending for the successor, and string-effect tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_pend_ff <= 1'b0;
			str_ff <= tsu_pkg::TSU_STR_NONE;
		end else if (commit) begin
			if (discard_ff) begin
				skip_pend_ff <= 1'b0;
			end else begin
				str_ff <= str_of(instr_ff.op);
				case (instr_ff.op)
					tsu_pkg::TSU_OP_MOV_A_PTR_INC: skip_pend_ff <= regs_ff.l == 4'hF;
					tsu_pkg::TSU_OP_XCH_A_PTR_INC: skip_pend_ff <= regs_ff.l == 4'hF;
					tsu_pkg::TSU_OP_MOV_A_PTR_DEC: skip_pend_ff <= regs_ff.l == 4'h0;
					tsu_pkg::TSU_OP_XCH_A_PTR_DEC: skip_pend_ff <= regs_ff.l == 4'h0;
					default: skip_pend_ff <= 1'b0;
				endcase
			end
		end
	end

	// Low pointer nibble after a post-modify access
	always_comb begin
		case (instr_ff.op)
			tsu_pkg::TSU_OP_MOV_A_PTR_INC, tsu_pkg::TSU_OP_XCH_A_PTR_INC: nxt_ptr_l = regs_ff.l + 4'h1;
			tsu_pkg::TSU_OP_MOV_A_PTR_DEC, tsu_pkg::TSU_OP_XCH_A_PTR_DEC: nxt_ptr_l = regs_ff.l - 4'h1;
			default: nxt_ptr_l = regs_ff.l;
		endcase
	end

	// Working registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs_ff <= `TSU_REGS_RST;
		end else if (wr_acc && paddr[11:0] == `TSU_OFS_REGS && state_ff == tsu_pkg::TSU_ST_IDLE) begin
			regs_ff <= pwdata[23:0];
		end else if (commit && !discard_ff) begin
			regs_ff.l <= nxt_ptr_l;
			case (instr_ff.op)
				tsu_pkg::TSU_OP_MOV_A_IMM: regs_ff.a <= instr_ff.imm[3:0];
				tsu_pkg::TSU_OP_MOV_XA_IMM: {regs_ff.x, regs_ff.a} <= instr_ff.imm;
				tsu_pkg::TSU_OP_MOV_PTR_IMM: {regs_ff.h, regs_ff.l} <= instr_ff.imm;
				tsu_pkg::TSU_OP_MOV_MEM_A, tsu_pkg::TSU_OP_OTHER,
				tsu_pkg::TSU_OP_TABLE_CALL, tsu_pkg::TSU_OP_ABS_BRANCH: regs_ff.a <= regs_ff.a;
				default: regs_ff.a <= mem_rdata;
			endcase
		end
	end

	// Stores and exchanges write the old accumulator back
	assign mem_we = commit && !discard_ff && (instr_ff.op == tsu_pkg::TSU_OP_MOV_MEM_A
		|| instr_ff.op == tsu_pkg::TSU_OP_XCH_A_MEM || instr_ff.op == tsu_pkg::TSU_OP_XCH_A_PTR
		|| instr_ff.op == tsu_pkg::TSU_OP_XCH_A_PTR_INC || instr_ff.op == tsu_pkg::TSU_OP_XCH_A_PTR_DEC);

	tsu_mem #(.AW(AW), .DW(4)) u_mem (
		.clk(pclk),
		.rst_n(presetn),
		.addr(maddr_ff),
		.we(mem_we),
		.wdata(regs_ff.a),
		.rdata(mem_rdata)
	);

	// Configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= `TSU_CFG_RST;
		end else if (wr_acc && paddr[11:0] == `TSU_OFS_CFG) begin
			cfg_ff <= {22'h0, pwdata[9:8], pwdata[7:4], 3'h0, pwdata[0]};
		end
	end

	// Read mux
	always_comb begin
		case (paddr[11:0])
			`TSU_OFS_INSTR: rd_val = instr_ff;
			`TSU_OFS_CFG: rd_val = cfg_ff;
			`TSU_OFS_REGS: rd_val = {8'h00, regs_ff};
			`TSU_OFS_STAT: rd_val = {20'h0, str_ff, last_disc_ff, skip_pend_ff, last_cyc_ff,
				3'h0, state_ff == tsu_pkg::TSU_ST_RUN};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// APB answer: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready_ff <= 1'b1;
			pslverr_ff <= !mapped || paddr[1:0] != 2'h0;
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// Busy flag output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_busy <= 1'b0;
		end else begin
			exec_busy <= issue || (state_ff == tsu_pkg::TSU_ST_RUN && !commit);
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

endmodule // tsu_core

`default_nettype wire

// File: sim/tsu_ram_model.sv
// Behavioural data memory: banks 0, 1 and 15, 256 nibbles each.
// Assumes the bench keeps en and sel equal to the configuration written.
`timescale 1ns/1ps
`default_nettype none

module tsu_ram_model;
	logic en = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [3:0] m [16][256];

	// Kind 0 pointer pair, 1 direct operand, 2 restricted pair
	function automatic logic [3:0] bank(input logic [1:0] k, input logic [11:0] ad);
		if (k == 2'h2) return 4'h0;
		if (!en) return (k == 2'h1 && ad[7]) ? 4'hF : 4'h0;
		return (sel == 4'h1 || sel == 4'hF) ? sel : 4'h0;
	endfunction

	task automatic put(input logic [1:0] k, input logic [11:0] ad, input logic [3:0] v);
		m[bank(k, ad)][ad[7:0]] = v;
	endtask

	function automatic logic [3:0] get(input logic [1:0] k, input logic [11:0] ad);
		return m[bank(k, ad)][ad[7:0]];
	endfunction
endmodule // tsu_ram_model

`default_nettype wire

// File: sim/tsu_core_checker.sv
// Port checker for tsu_core, attached by bind.
// Assumes configuration is written only while no instruction runs.
`timescale 1ns/1ps
`default_nettype none
`include "tsu_params.svh"

module tsu_core_checker #(
	parameter int AW = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic exec_busy
);
	logic [1:0] sel_ff;
	logic [9:0] cnt_ff;
	logic [7:0] div;
	logic issue;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign issue = psel && penable && pready && pwrite && paddr[11:0] == `TSU_OFS_INSTR;
	assign div = sel_ff[1] ? (sel_ff[0] ? `TSU_DIV3 : `TSU_DIV2) : (sel_ff[0] ? `TSU_DIV1 : `TSU_DIV0);

	// Clock select last written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ff <= 2'h0;
		end else if (psel && penable && pready && pwrite && paddr[11:0] == `TSU_OFS_CFG) begin
			sel_ff <= pwdata[9:8];
		end
	end

	// Length of the current busy span
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 10'h0;
		end else begin
			cnt_ff <= exec_busy ? cnt_ff + 10'h1 : 10'h0;
		end
	end

	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_data_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("error read not zero");
	rst_quiet_a: assert property ($rose(presetn) |-> !pready && !exec_busy)
		else $error("outputs active after reset");
	issue_busy_a: assert property (issue && !exec_busy |-> ##[1:2] exec_busy)
		else $error("issue did not start");
	busy_min_a: assert property ($rose(exec_busy) |-> exec_busy [*4])
		else $error("busy shorter than a cycle");
	busy_len_a: assert property ($fell(exec_busy) |-> cnt_ff >= {2'h0, div})
		else $error("busy shorter than divider");
	busy_max_a: assert property ($rose(exec_busy) |-> ##[4:1000] !exec_busy)
		else $error("busy never ended");

	cover property (issue);
	cover property (pslverr);
	cover property ($fell(exec_busy) && sel_ff == 2'h3);
endmodule // tsu_core_checker

bind tsu_core tsu_core_checker #(.AW(AW)) i_tsu_core_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));

`default_nettype wire

// File: sim/test_transfer_skip_timing_unit.sv
// Self-checking bench for the transfer and skip timing unit.
// Assumes tsu_core, the memory model and the checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "tsu_params.svh"

module test_transfer_skip_timing_unit;
	localparam logic [31:0] SM = 32'h3F0;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic exec_busy;
	logic [31:0] q;
	logic qerr;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc;

	tsu_core #(.AW(10)) i_tsu_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));
	tsu_ram_model i_tsu_ram_model ();

	always #2 pclk = ~pclk;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		qerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [31:0] iw(input logic [3:0] op, input logic [1:0] b,
		input logic [7:0] im, input logic [11:0] ad);
		return {4'h0, ad, im, 2'h0, b, op};
	endfunction

	task automatic exec(input logic [31:0] w);
		apb(1'b1, `TSU_OFS_INSTR, w);
		repeat (2) @(posedge pclk);
		cyc = 3;
		while (exec_busy === 1'b1 && cyc < 2000) begin
			@(posedge pclk);
			cyc++;
		end
		chk({31'h0, exec_busy}, 32'h0000_0000);
		apb(1'b0, `TSU_OFS_STAT, 32'h0);
	endtask

	task automatic cfg(input logic e, input logic [3:0] s, input logic [1:0] c);
		apb(1'b1, `TSU_OFS_CFG, {22'h0, c, s, 3'h0, e});
		i_tsu_ram_model.en = e;
		i_tsu_ram_model.sel = s;
	endtask

	task automatic regs(input logic [31:0] v);
		apb(1'b1, `TSU_OFS_REGS, v);
	endtask

	task automatic rr;
		apb(1'b0, `TSU_OFS_REGS, 32'h0);
	endtask

	task automatic t_clock;
		logic [7:0] dv [4] = '{`TSU_DIV0, `TSU_DIV1, `TSU_DIV2, `TSU_DIV3};
		apb(1'b0, 12'h010, 32'h0);
		chk(q, 32'h0000_0000);
		chk({31'h0, qerr}, 32'h0000_0001);
		apb(1'b0, `TSU_OFS_CFG, 32'h0);
		chk(q, `TSU_CFG_RST);
		chk({31'h0, qerr}, 32'h0000_0000);
		for (int s = 0; s < 4; s++) begin
			cfg(1'b0, 4'h0, 2'(s));
			exec(iw(4'h0, 2'h1, 8'h0, 12'h0));
			chk(32'(cyc), {24'h0, dv[s]} + 32'h2);
		end
		cfg(1'b0, 4'h0, 2'h0);
		$display("t_clock done");
	endtask

	task automatic t_inc;
		regs(32'h0000_F005);
		exec(iw(4'hC, 2'h2, 8'h0, 12'h00F));
		i_tsu_ram_model.put(2'h1, 12'h00F, 4'h5);
		regs(32'h0000_F000);
		exec(iw(4'h5, 2'h1, 8'h0, 12'h0));
		chk(q & SM, 32'h120);
		rr;
		chk(q & 32'hF00F, {28'h0, i_tsu_ram_model.get(2'h0, 12'h00F)});
		exec(iw(4'h0, 2'h2, 8'h0, 12'h0));
		chk(q & SM, 32'h210);
		exec(iw(4'h0, 2'h1, 8'h0, 12'h0));
		chk(q & SM, 32'h010);
		$display("t_inc done");
	endtask

	task automatic t_dec;
		regs(32'h7);
		exec(iw(4'hC, 2'h2, 8'h0, 12'h000));
		i_tsu_ram_model.put(2'h1, 12'h000, 4'h7);
		regs(32'h0);
		exec(iw(4'h6, 2'h1, 8'h0, 12'h0));
		chk(q & SM, 32'h120);
		rr;
		chk(q & 32'hF00F, {16'h0, 4'hF, 8'h0, i_tsu_ram_model.get(2'h0, 12'h0)});
		exec(iw(4'hF, 2'h3, 8'h0, 12'h0));
		chk(q & SM, 32'h220);
		$display("t_dec done");
	endtask

	task automatic t_xinc;
		regs(32'hF009);
		exec(iw(4'h8, 2'h1, 8'h0, 12'h0));
		chk(q & SM, 32'h120);
		rr;
		chk(q & 32'hF00F, {28'h0, i_tsu_ram_model.get(2'h0, 12'h00F)});
		i_tsu_ram_model.put(2'h0, 12'h00F, 4'h9);
		exec(iw(4'hE, 2'h3, 8'h0, 12'h0));
		chk(q & SM, 32'h210);
		regs(32'hF000);
		exec(iw(4'h4, 2'h1, 8'h0, 12'h0));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h0, 12'h00F)});
		$display("t_xinc done");
	endtask

	task automatic t_xdec;
		regs(32'h3);
		exec(iw(4'h9, 2'h1, 8'h0, 12'h0));
		chk(q & SM, 32'h120);
		rr;
		chk(q & 32'hF00F, {16'h0, 4'hF, 8'h0, i_tsu_ram_model.get(2'h0, 12'h0)});
		exec(iw(4'h0, 2'h3, 8'h0, 12'h0));
		chk(q & SM, 32'h220);
		$display("t_xdec done");
	endtask

	task automatic t_bank;
		cfg(1'b1, 4'h1, 2'h0);
		regs(32'h0209);
		exec(iw(4'hC, 2'h2, 8'h0, 12'h020));
		i_tsu_ram_model.put(2'h1, 12'h020, 4'h9);
		cfg(1'b0, 4'h0, 2'h0);
		regs(32'h0203);
		exec(iw(4'hC, 2'h2, 8'h0, 12'h020));
		i_tsu_ram_model.put(2'h1, 12'h020, 4'h3);
		cfg(1'b1, 4'h1, 2'h0);
		regs(32'h0200);
		exec(iw(4'h4, 2'h1, 8'h0, 12'h0));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h0, 12'h020)});
		regs(32'h0002_0000);
		exec(iw(4'hA, 2'h1, 8'h0, 12'h0));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h2, 12'h020)});
		cfg(1'b0, 4'h0, 2'h0);
		regs(32'h6);
		exec(iw(4'hC, 2'h2, 8'h0, 12'hFA0));
		i_tsu_ram_model.put(2'h1, 12'hFA0, 4'h6);
		cfg(1'b1, 4'hF, 2'h0);
		regs(32'h0A00);
		exec(iw(4'h4, 2'h1, 8'h0, 12'h0));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h0, 12'h0A0)});
		cfg(1'b0, 4'h0, 2'h0);
		$display("t_bank done");
	endtask

	task automatic t_str;
		exec(iw(4'h1, 2'h1, 8'h05, 12'h0));
		chk(q & SM, 32'h010);
		exec(iw(4'h1, 2'h1, 8'h06, 12'h0));
		chk(q & SM, 32'h210);
		rr;
		chk(q & 32'hF, 32'h5);
		exec(iw(4'h3, 2'h2, 8'h4C, 12'h0));
		chk(q & SM, 32'h020);
		$display("t_str done");
	endtask

	task automatic t_misc;
		exec(iw(4'h2, 2'h2, 8'hA7, 12'h0));
		chk(q & SM, 32'h020);
		exec(iw(4'h1, 2'h1, 8'h03, 12'h0));
		chk(q & SM, 32'h210);
		rr;
		chk(q & 32'hFF, 32'hA7);
		regs(32'h3);
		exec(iw(4'hC, 2'h2, 8'h0, 12'h090));
		i_tsu_ram_model.put(2'h1, 12'h090, 4'h3);
		regs(32'h8);
		exec(iw(4'hD, 2'h2, 8'h0, 12'h090));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h1, 12'h090)});
		i_tsu_ram_model.put(2'h1, 12'h090, 4'h8);
		exec(iw(4'hB, 2'h2, 8'h0, 12'h090));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h1, 12'h090)});
		regs(32'hF001);
		exec(iw(4'h7, 2'h1, 8'h0, 12'h0));
		chk(q & SM, 32'h010);
		rr;
		chk(q & 32'hF00F, {16'h0, 4'hF, 8'h0, i_tsu_ram_model.get(2'h0, 12'h00F)});
		i_tsu_ram_model.put(2'h0, 12'h00F, 4'h1);
		exec(iw(4'h4, 2'h1, 8'h0, 12'h0));
		rr;
		chk(q & 32'hF, {28'h0, i_tsu_ram_model.get(2'h0, 12'h00F)});
		$display("t_misc done");
	endtask

	task automatic end_of_test;
		$display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_clock;
		t_inc;
		t_dec;
		t_xinc;
		t_xdec;
		t_bank;
		t_str;
		t_misc;
		end_of_test;
	end

	initial begin
		#200000;
		fail_count++;
		end_of_test;
	end
endmodule // test_transfer_skip_timing_unit

`default_nettype wire
